// ==== pkg/tise_pkg.sv ====
// tise_pkg: register map, field positions, encodings and state records of the
// 16-bit interval / square-wave / event timer.
// assumes a single 25 MHz peripheral clock and an AHB-Lite register port.
package tise_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_PRESC = 8'h04;
  localparam logic [7:0] ADDR_OUTC = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_CMP1 = 8'h10;
  localparam logic [7:0] ADDR_CMP2 = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;

  // field positions
  localparam int MODE_LSB = 2;
  localparam int ES_LSB = 4;
  localparam int OUT_EN_BIT = 0;
  localparam int OUT_INV_BIT = 1;
  localparam int STAT_FIRST = 0;
  localparam int STAT_SECOND = 1;

  // encodings
  localparam logic [1:0] OP_STOP = 2'h0;
  localparam logic [1:0] OP_EDGE_CLR = 2'h2;
  localparam logic [1:0] OP_MATCH_CLR = 2'h3;
  localparam logic [1:0] EVT_SEL = 2'h3;
  localparam logic [1:0] ES_FALL = 2'h0;
  localparam logic [1:0] ES_RISE = 2'h1;
  localparam logic [1:0] ES_BOTH = 2'h3;
  localparam logic [7:0] SQUARE_CFG = 8'h03;

  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [7:0] RST_PRESC = 8'h00;
  localparam logic [7:0] RST_OUTC = 8'h00;
  localparam logic [15:0] RST_CMP = 16'h0000;
  localparam logic [1:0] RST_MASK = 2'h3;

  // filtered event input as seen by the counter
  typedef struct packed {
    logic edge_seen;
    logic level;
  } tise_evt_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic samp;
    logic level;
    logic edge_seen;
  } tise_flt_state_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] presc;
    logic [7:0] outc;
    logic [15:0] cnt;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [1:0] status;
    logic [1:0] mask;
    logic wave;
    logic primed;
    logic [7:0] div;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] hrdata;
  } tise_state_s;

endpackage : tise_pkg

// ==== design/tise_edge_filter.sv ====
// tise_edge_filter: synchroniser and two-sample noise filter for the event pin.
// assumes the pin is asynchronous to clk; edge_sel comes from clk-domain logic.
`timescale 1ns/1ps
module tise_edge_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and selection
  input wire logic event_input_pin,
  input wire logic [1:0] edge_sel,
  // filtered result
  output tise_pkg::tise_evt_s evt
);
  tise_pkg::tise_flt_state_s st;
  tise_pkg::tise_flt_state_s next_st;

  always_comb begin
    next_st = st;
    next_st.sync1 = event_input_pin;
    next_st.sync2 = st.sync1;
    next_st.samp = st.sync2;
    next_st.edge_seen = 1'b0;
    // a level counts only once two samples in a row agree
    if (st.sync2 == st.samp && st.samp != st.level) begin
      next_st.level = st.samp;
      unique case (edge_sel)
        tise_pkg::ES_FALL: next_st.edge_seen = ~st.samp;
        tise_pkg::ES_RISE: next_st.edge_seen = st.samp;
        tise_pkg::ES_BOTH: next_st.edge_seen = 1'b1;
        default: next_st.edge_seen = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign evt.edge_seen = st.edge_seen;
  assign evt.level = st.level;

endmodule : tise_edge_filter

// ==== design/tise_timer.sv ====
// tise_timer: 16-bit interval timer, square-wave generator and event counter
// behind an AHB-Lite slave with sticky, maskable match interrupts.
// assumes one clock, a single AHB-Lite master and an asynchronous event pin.
//
// Summary of operation
// - mode field 11 starts counting on the selected count clock
// - counter equal to first compare clears to zero and flags first match
// - compare value M gives a match period of M+1 count clocks
// - counter equal to second compare flags second match, even unused
// - mode field 00 stops counting and returns the counter to zero
// - reading the count register returns the present count
// - output control 03H in interval mode gives a square wave
// - each first match clears, flags and inverts the wave output
// - clock select bits 11 with mode 11 count valid event edges
// - later matches in event mode come every compare+1 edges
// - first match after start comes after compare+2 edges
// - event pin sampled each clock, edge valid after two equal samples
// - edge select 00 falling, 01 rising, 11 both, 10 none
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module tise_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins
  input wire logic event_input_pin,
  output logic timer_wave_out,
  // interrupt
  output logic irq
);
  tise_pkg::tise_state_s st;
  tise_pkg::tise_state_s next_st;
  tise_pkg::tise_evt_s evt;
  logic run;
  logic evt_mode;
  logic cen;
  logic match1;
  logic match2;
  logic addr_rd;
  logic addr_wr;

  // divided count clock as a one-cycle enable
  function automatic logic div_tick(input logic [2:0] sel, input logic [7:0] div);
    logic t;
    t = 1'b0;
    unique case (sel)
      3'h0: t = 1'b1;
      3'h1: t = div[0];
      3'h2: t = &div[1:0];
      3'h4: t = &div;
      3'h5: t = &div[3:0];
      default: t = 1'b0;
    endcase
    return t;
  endfunction : div_tick

  function automatic logic [31:0] rd_value(input tise_pkg::tise_state_s s,
                                           input logic [7:0] a);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (a)
      tise_pkg::ADDR_MODE: v = {28'h0000000, s.mode, 2'h0};
      tise_pkg::ADDR_PRESC: v = {24'h000000, s.presc};
      tise_pkg::ADDR_OUTC: v = {24'h000000, s.outc};
      tise_pkg::ADDR_COUNT: v = {16'h0000, s.cnt};
      tise_pkg::ADDR_CMP1: v = {16'h0000, s.cmp1};
      tise_pkg::ADDR_CMP2: v = {16'h0000, s.cmp2};
      tise_pkg::ADDR_STAT: v = {30'h00000000, s.status};
      tise_pkg::ADDR_MASK: v = {30'h00000000, s.mask};
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction : rd_value

  tise_edge_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .event_input_pin(event_input_pin),
    .edge_sel(st.presc[tise_pkg::ES_LSB +: 2]),
    .evt(evt)
  );

  assign run = (st.mode == tise_pkg::OP_MATCH_CLR);
  assign evt_mode = (st.presc[1:0] == tise_pkg::EVT_SEL);
  // the first event edge after start only arms the counter
  assign cen = evt_mode ? (evt.edge_seen & st.primed) : div_tick(st.presc[2:0], st.div);
  assign match1 = run & cen & (st.cnt == st.cmp1);
  assign match2 = run & cen & (st.cnt == st.cmp2);
  assign addr_rd = hsel & hready & htrans[1] & ~hwrite;
  assign addr_wr = hsel & hready & htrans[1] & hwrite;

  always_comb begin
    logic [1:0] w1c;
    w1c = 2'h0;
    next_st = st;
    next_st.dph_wr = addr_wr;
    next_st.dph_addr = addr_wr ? haddr : st.dph_addr;
    next_st.hrdata = addr_rd ? rd_value(st, haddr) : 32'h00000000;

    // register writes in the data phase
    if (st.dph_wr) begin
      unique case (st.dph_addr)
        tise_pkg::ADDR_MODE: next_st.mode = hwdata[tise_pkg::MODE_LSB +: 2];
        tise_pkg::ADDR_PRESC: next_st.presc = hwdata[7:0];
        tise_pkg::ADDR_OUTC: next_st.outc = hwdata[7:0];
        tise_pkg::ADDR_CMP1: next_st.cmp1 = hwdata[15:0];
        tise_pkg::ADDR_CMP2: next_st.cmp2 = hwdata[15:0];
        tise_pkg::ADDR_STAT: w1c = hwdata[1:0];
        tise_pkg::ADDR_MASK: next_st.mask = hwdata[1:0];
        default: next_st.mode = st.mode;
      endcase
    end

    // counting
    if (!run) begin
      // stopped: counter and output back to their initial state
      next_st.cnt = 16'h0000;
      next_st.div = 8'h00;
      next_st.primed = 1'b0;
      next_st.wave = 1'b0;
    end else begin
      next_st.div = st.div + 8'h01;
      if (evt_mode && evt.edge_seen && !st.primed) begin
        next_st.primed = 1'b1;
      end
      if (match1) begin
        next_st.cnt = 16'h0000;
        if (st.outc[tise_pkg::OUT_EN_BIT] && st.outc[tise_pkg::OUT_INV_BIT]) begin
          next_st.wave = ~st.wave;
        end
      end else if (cen) begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
    if (!st.outc[tise_pkg::OUT_EN_BIT]) begin
      next_st.wave = 1'b0;
    end

    // sticky flags: a new event wins over a clear in the same cycle
    next_st.status = (st.status & ~w1c) | {match2, match1};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= tise_pkg::RST_MODE;
      st.presc <= tise_pkg::RST_PRESC;
      st.outc <= tise_pkg::RST_OUTC;
      st.cmp1 <= tise_pkg::RST_CMP;
      st.cmp2 <= tise_pkg::RST_CMP;
      st.mask <= tise_pkg::RST_MASK;
    end else begin
      st <= next_st;
    end
  end

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign timer_wave_out = st.wave;
  // a set mask bit blocks its flag; spurious second matches stay hidden
  assign irq = |(st.status & ~st.mask);

  match_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    match1 |=> (st.cnt == 16'h0000) && st.status[tise_pkg::STAT_FIRST])
    else $error("first match did not clear counter and set flag");

  stop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st.mode == tise_pkg::OP_STOP) |=> (st.cnt == 16'h0000) && !st.wave)
    else $error("stopped counter not at zero");

  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (run && cen && !match1 && next_st.mode == tise_pkg::OP_MATCH_CLR)
      |=> st.cnt == $past(st.cnt) + 16'h0001)
    else $error("counter did not step by one");

  hold_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (run && !cen && next_st.mode == tise_pkg::OP_MATCH_CLR)
      |=> $stable(st.cnt))
    else $error("counter moved without a count enable");

  wave_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (match1 && st.outc == tise_pkg::SQUARE_CFG && next_st.outc == tise_pkg::SQUARE_CFG)
      |=> st.wave != $past(st.wave))
    else $error("wave output not inverted on match");

  second_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    match2 |=> st.status[tise_pkg::STAT_SECOND])
    else $error("second match flag not set");

  event_prime_a: assert property (@(posedge clk) disable iff (!rst_n)
    (run && evt_mode && evt.edge_seen && !st.primed && next_st.mode == tise_pkg::OP_MATCH_CLR)
      |=> st.primed && st.cnt == $past(st.cnt))
    else $error("first event edge after start was counted");

  count_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (addr_rd && haddr == tise_pkg::ADDR_COUNT) |=> hrdata == {16'h0000, $past(st.cnt)})
    else $error("count read returned wrong value");

  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (match2 && st.mask[tise_pkg::STAT_SECOND] && !(|(st.status & ~st.mask)) && !match1)
      |=> !irq || $past(st.dph_wr))
    else $error("masked second match raised the interrupt");

endmodule : tise_timer

// ==== tb/tise_pin_model.sv ====
// tise_pin_model: far side of the timer, drives the event pin.
// assumes pulse() is called right after a rising clk edge.
`timescale 1ns/1ps
module tise_pin_model (
  // clock
  input wire logic clk,
  // pin
  output logic event_input_pin
);
  initial event_input_pin = 1'b0;
  // high for w clocks, then a quiet gap so the filter settles
  task automatic pulse(input int w);
    event_input_pin <= 1'b1;
    repeat (w) @(posedge clk);
    event_input_pin <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pulse
endmodule : tise_pin_model

// ==== tb/timer16_interval_square_event_tb.sv ====
// timer16_interval_square_event_tb: self-checking bench for tise_timer.
// assumes this bench is the only ahb-lite master and the slave never waits.
`timescale 1ns/1ps
module timer16_interval_square_event_tb;
  localparam logic [31:0] RUN = 32'h0000000C;
  logic clk = 1'b0;
  logic rst_n;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout, hresp, timer_wave_out, irq, event_input_pin;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  tise_timer u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .event_input_pin(event_input_pin), .timer_wave_out(timer_wave_out), .irq(irq));
  tise_pin_model u_pin (.clk(clk), .event_input_pin(event_input_pin));
  task automatic close_out();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // a hang is cut short here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask : rd_chk
  // counts clocks while the wave pin holds lvl
  task automatic hold_time(input logic lvl, output int n);
    n = 0;
    while (timer_wave_out === lvl && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask : hold_time
  task automatic t_reset();
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h40, 32'h0);
    rd_chk("mode", tise_pkg::ADDR_MODE, 32'h0);
    rd_chk("presc", tise_pkg::ADDR_PRESC, 32'h0);
    rd_chk("outc", tise_pkg::ADDR_OUTC, 32'h0);
    rd_chk("cmp1", tise_pkg::ADDR_CMP1, 32'h0);
    rd_chk("mask", tise_pkg::ADDR_MASK, 32'h3);
    rd_chk("count", tise_pkg::ADDR_COUNT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : t_reset
  task automatic t_square();
    int n;
    wr(tise_pkg::ADDR_CMP1, 32'h2);
    wr(tise_pkg::ADDR_OUTC, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(tise_pkg::ADDR_PRESC, i);
      wr(tise_pkg::ADDR_MODE, RUN);
      hold_time(1'b0, n);
      hold_time(1'b1, n);
      chk("wave half period", 32'd3 << i, n);
      wr(tise_pkg::ADDR_MODE, 32'h0);
      // counter clears one clock after the stop write lands
      @(posedge clk);
      rd_chk("count stopped", tise_pkg::ADDR_COUNT, 32'h0);
      chk("wave stopped", 32'h0, {31'h0, timer_wave_out});
    end
  endtask : t_square
  task automatic t_irq();
    logic [31:0] q1, q2;
    wr(tise_pkg::ADDR_CMP1, 32'hFFFF);
    wr(tise_pkg::ADDR_PRESC, 32'h0);
    wr(tise_pkg::ADDR_MODE, RUN);
    bus(1'b0, tise_pkg::ADDR_COUNT, 32'h0, q1);
    bus(1'b0, tise_pkg::ADDR_COUNT, 32'h0, q2);
    chk("count step", q1 + 32'd2, q2);
    wr(tise_pkg::ADDR_MODE, 32'h0);
    wr(tise_pkg::ADDR_CMP1, 32'h2);
    wr(tise_pkg::ADDR_CMP2, 32'h1);
    wr(tise_pkg::ADDR_MASK, 32'h2);
    wr(tise_pkg::ADDR_STAT, 32'h3);
    wr(tise_pkg::ADDR_MODE, RUN);
    repeat (20) @(posedge clk);
    wr(tise_pkg::ADDR_MODE, 32'h0);
    rd_chk("status both", tise_pkg::ADDR_STAT, 32'h3);
    chk("irq first", 32'h1, {31'h0, irq});
    wr(tise_pkg::ADDR_STAT, 32'h1);
    rd_chk("status w1c", tise_pkg::ADDR_STAT, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(tise_pkg::ADDR_MASK, 32'h0);
    rd_chk("mask", tise_pkg::ADDR_MASK, 32'h0);
    chk("irq second", 32'h1, {31'h0, irq});
    wr(tise_pkg::ADDR_STAT, 32'h2);
    rd_chk("status clear", tise_pkg::ADDR_STAT, 32'h0);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask : t_irq
  task automatic t_event();
    logic [1:0] es_tab [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
    logic [31:0] cnt_tab [4] = '{32'h1, 32'h3, 32'h1, 32'h0};
    // first valid edge only arms, hence one count less than edges
    wr(tise_pkg::ADDR_CMP1, 32'hFFFF);
    wr(tise_pkg::ADDR_CMP2, 32'hFFFF);
    for (int i = 0; i < 4; i++) begin
      wr(tise_pkg::ADDR_PRESC, {26'h0, es_tab[i], 4'h3});
      wr(tise_pkg::ADDR_MODE, RUN);
      u_pin.pulse(3);
      u_pin.pulse(3);
      u_pin.pulse(1);
      rd_chk("event count", tise_pkg::ADDR_COUNT, cnt_tab[i]);
      wr(tise_pkg::ADDR_MODE, 32'h0);
    end
    wr(tise_pkg::ADDR_CMP1, 32'h2);
    wr(tise_pkg::ADDR_PRESC, 32'h13);
    wr(tise_pkg::ADDR_MODE, RUN);
    repeat (3) u_pin.pulse(3);
    rd_chk("status early", tise_pkg::ADDR_STAT, 32'h0);
    u_pin.pulse(3);
    rd_chk("status first", tise_pkg::ADDR_STAT, 32'h1);
    wr(tise_pkg::ADDR_STAT, 32'h1);
    repeat (2) u_pin.pulse(3);
    rd_chk("status later", tise_pkg::ADDR_STAT, 32'h0);
    u_pin.pulse(3);
    rd_chk("status again", tise_pkg::ADDR_STAT, 32'h1);
    wr(tise_pkg::ADDR_MODE, 32'h0);
  endtask : t_event
  // reset while the wave runs must bring mode, presc, outc, cmp1, mask and count back
  task automatic t_midreset();
    wr(tise_pkg::ADDR_PRESC, 32'h0);
    wr(tise_pkg::ADDR_CMP1, 32'h2);
    wr(tise_pkg::ADDR_OUTC, 32'h3);
    wr(tise_pkg::ADDR_MODE, RUN);
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("wave after reset", 32'h0, {31'h0, timer_wave_out});
    t_reset();
  endtask : t_midreset
  initial begin
    rst_n <= 1'b0;
    hsel <= 1'b0;
    haddr <= 8'h00;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h00000000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_square();
    t_irq();
    t_event();
    t_midreset();
    close_out();
  end
endmodule : timer16_interval_square_event_tb
